// ==== hdl/ana_adv_regs.sv ====
// Functional notes
// - writable further page request at bit 15
// - writable far fault bit 13, resets zero
// - writable extended page capable bit 12, zero
// - technology ability field occupies bits 11:5
// - pause bits 11 and 10, writable, zero
// - bit 9 four pair reads zero always
// - speed bits 8 to 5 writable, reset one
// - speed bit defaults captured from strap pins
// - selector bits 4:0 always read one
// - partner ability register at 0x0005, resets zero
// - advertisement register at 0x0004, nominal 0x01e1
`timescale 1ns/1ns
`include "ana_adv_map.svh"

module ana_adv_regs
    import ana_adv_pkg::*;
#(
    parameter int ADDR_WIDTH = 5
) (
    input wire logic ref_clk,
    input wire logic rst,
    // management access, on the device clock
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [ADDR_WIDTH-1:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    output logic reg_rvalid,
    // configuration straps for the four speed ability bits
    input wire logic [3:0] speed_strap,
    // base page received from the partner by the arbitration logic
    input wire logic partner_page_load,
    input wire logic [15:0] partner_page,
    // base link code word and the further page request toward arbitration
    output logic [15:0] base_code_word,
    output logic further_page_request,
    output logic strap_loaded
);
    ////////////////////////////////////////////////////////////////////////
    initial begin
        if (ADDR_WIDTH < 5) begin
            $error("ana_adv_regs: ADDR_WIDTH must be at least 5");
        end

        // the field map must match the flops that back it
        if (`ANA_TECH_HI != `ANA_BIT_ASYM_HALT) begin
            $error("ana_adv_regs: technology field must start at the asymmetric pause bit");
        end
        if (`ANA_TECH_LO != `ANA_SPEED_LO) begin
            $error("ana_adv_regs: technology field must end at the lowest speed bit");
        end
        if (`ANA_BIT_FOUR_PAIR != `ANA_SPEED_HI + 1) begin
            $error("ana_adv_regs: four pair bit must sit just above the speed bits");
        end
        if (`ANA_SPEED_HI - `ANA_SPEED_LO + 1 != $bits(ana_speed_t)) begin
            $error("ana_adv_regs: speed field width must match the speed type");
        end
        if ($bits(`ANA_SPEED_RESET) != $bits(ana_speed_t)) begin
            $error("ana_adv_regs: speed reset value must match the speed type");
        end
        if (`ANA_SEL_HI - `ANA_SEL_LO + 1 != $bits(`ANA_SELECTOR_8023)) begin
            $error("ana_adv_regs: selector field width must match its code");
        end
    end

    ana_speed_t strap_sync;
    ana_strap_state_t strap_state;
    logic further_page;
    logic far_fault_advertise;
    logic extended_page_capable;
    logic asym_flow_halt_advertise;
    logic sym_flow_halt_advertise;
    ana_speed_t speed_advertise;
    ana_word_t local_negotiation_advertise;
    ana_word_t partner_base_page_ability;
    logic hit_local;
    logic hit_partner;
    logic write_local;
    ana_word_t read_word;
    // nominal word; its further page bit seeds that flop's reset value
    localparam ana_word_t ADV_NOMINAL = `ANA_LOCAL_ADV_NOMINAL;

    ////////////////////////////////////////////////////////////////////////
    // strap pins are asynchronous, so they cross two flops first;
    // the first flop may go metastable, so only the second is ever read
    ana_sync2 #(
        .WIDTH($bits(ana_speed_t))
    ) u_strap_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .async_in(speed_strap),
        .sync_out(strap_sync)
    );

    // strap capture: the synchroniser needs two edges after reset before its
    // output carries the pins, so the load waits in wait and fill, then happens once;
    // loading any earlier would seed the speed bits with the synchroniser's reset zeros
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            strap_state <= ANA_STRAP_WAIT;
        end else begin
            unique case (strap_state)
                ANA_STRAP_WAIT: strap_state <= ANA_STRAP_FILL;
                ANA_STRAP_FILL: strap_state <= ANA_STRAP_LOAD;
                ANA_STRAP_LOAD: strap_state <= ANA_STRAP_DONE;
                ANA_STRAP_DONE: strap_state <= ANA_STRAP_DONE;
            endcase
        end
    end

    // strap done flag: set by the load, held until the next reset
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            strap_loaded <= 1'b0;
        end else begin
            strap_loaded <= (strap_state == ANA_STRAP_LOAD) || strap_loaded;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // address decode
    assign hit_local = (reg_addr == ADDR_WIDTH'(`ANA_ADDR_LOCAL_ADV));
    assign hit_partner = (reg_addr == ADDR_WIDTH'(`ANA_ADDR_PARTNER));
    // partner register is read only: no write strobe is decoded for it
    assign write_local = reg_wr && hit_local;

    // control bits written by software
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            further_page <= ADV_NOMINAL[`ANA_BIT_FURTHER_PAGE];
            far_fault_advertise <= 1'b0;
            extended_page_capable <= 1'b0;
        end else if (write_local) begin
            further_page <= reg_wdata[`ANA_BIT_FURTHER_PAGE];
            far_fault_advertise <= reg_wdata[`ANA_BIT_FAR_FAULT];
            extended_page_capable <= reg_wdata[`ANA_BIT_EXT_PAGE];
        end
    end

    // pause advertisement bits
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            asym_flow_halt_advertise <= 1'b0;
            sym_flow_halt_advertise <= 1'b0;
        end else if (write_local) begin
            asym_flow_halt_advertise <= reg_wdata[`ANA_BIT_ASYM_HALT];
            sym_flow_halt_advertise <= reg_wdata[`ANA_BIT_SYM_HALT];
        end
    end

    // speed bits: reset to all ones, then straps take over once, writes win after;
    // a write in the very cycle of the strap load wins, but a write made in wait or fill is undone by the load
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            speed_advertise <= `ANA_SPEED_RESET;
        end else if (write_local) begin
            speed_advertise <= reg_wdata[`ANA_SPEED_HI:`ANA_SPEED_LO];
        end else if (strap_state == ANA_STRAP_LOAD) begin
            speed_advertise <= strap_sync;
        end
    end

    // advertisement word; bit 14 and bit 9 are hard zero, selector fixed
    // this word is both the read value and the base link code word sent out
    always_comb begin
        local_negotiation_advertise = '0;
        local_negotiation_advertise[`ANA_BIT_FURTHER_PAGE] = further_page;
        local_negotiation_advertise[`ANA_BIT_FAR_FAULT] = far_fault_advertise;
        local_negotiation_advertise[`ANA_BIT_EXT_PAGE] = extended_page_capable;
        local_negotiation_advertise[`ANA_TECH_HI:`ANA_TECH_LO] = {asym_flow_halt_advertise,
            sym_flow_halt_advertise, 1'b0, speed_advertise};
        local_negotiation_advertise[`ANA_SEL_HI:`ANA_SEL_LO] = `ANA_SELECTOR_8023;
    end

    ////////////////////////////////////////////////////////////////////////
    // partner base page, loaded by arbitration, read only to software
    // all sixteen bits are kept as received, selector included
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            partner_base_page_ability <= `ANA_PARTNER_RESET;
        end else if (partner_page_load) begin
            partner_base_page_ability <= partner_page;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs toward arbitration, registered
    // the code word lags the register by one cycle, which keeps the output a plain flop
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            base_code_word <= `ANA_LOCAL_ADV_NOMINAL;
            further_page_request <= 1'b0;
        end else begin
            base_code_word <= local_negotiation_advertise;
            further_page_request <= further_page;
        end
    end

    // read mux; unmapped addresses answer zero so software can probe the space safely
    always_comb begin
        read_word = '0;
        if (hit_local) begin
            read_word = local_negotiation_advertise;
        end else if (hit_partner) begin
            read_word = partner_base_page_ability;
        end
    end

    // read path: answer one cycle after reg_rd; the data then stand until the next read,
    // and a write in the same cycle as the read is not yet visible in the answer
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= '0;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                reg_rdata <= read_word;
            end
        end
    end
endmodule

// ==== hdl/ana_adv_map.svh ====
`ifndef ANA_ADV_MAP_SVH
`define ANA_ADV_MAP_SVH
// register addresses within the management register space
`define ANA_ADDR_LOCAL_ADV 5'h04
`define ANA_ADDR_PARTNER 5'h05
// field positions of the advertisement word
`define ANA_BIT_FURTHER_PAGE 15
`define ANA_BIT_RESERVED 14
`define ANA_BIT_FAR_FAULT 13
`define ANA_BIT_EXT_PAGE 12
`define ANA_BIT_ASYM_HALT 11
`define ANA_BIT_SYM_HALT 10
`define ANA_BIT_FOUR_PAIR 9
`define ANA_TECH_HI 11
`define ANA_TECH_LO 5
`define ANA_SPEED_HI 8
`define ANA_SPEED_LO 5
`define ANA_SEL_HI 4
`define ANA_SEL_LO 0
// reset values and the fixed selector code
`define ANA_LOCAL_ADV_NOMINAL 16'h01e1
`define ANA_PARTNER_RESET 16'h0000
`define ANA_SELECTOR_8023 5'h01
`define ANA_SPEED_RESET 4'hf
`endif

// ==== hdl/ana_adv_pkg.sv ====
package ana_adv_pkg;
    typedef logic [15:0] ana_word_t;
    typedef logic [3:0] ana_speed_t;
    typedef enum logic [1:0] {
        ANA_STRAP_WAIT = 2'b00,
        ANA_STRAP_LOAD = 2'b01,
        ANA_STRAP_DONE = 2'b10,
        ANA_STRAP_FILL = 2'b11
    } ana_strap_state_t;
endpackage

// ==== hdl/ana_sync2.sv ====
`timescale 1ns/1ns
// two-flop synchroniser for pin inputs
module ana_sync2 #(
    parameter int WIDTH = 4
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta;

    initial begin
        if (WIDTH < 1) begin
            $error("ana_sync2: WIDTH must be at least 1");
        end
    end

    // first stage feeds only the second
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            meta <= '0;
            sync_out <= '0;
        end else begin
            meta <= async_in;
            sync_out <= meta;
        end
    end
endmodule

// ==== testbench/ana_adv_monitor.sv ====
`timescale 1ns/1ns
module ana_adv_monitor #(
    parameter int ADDR_WIDTH = 5
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [ADDR_WIDTH-1:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire logic [3:0] speed_strap,
    input wire logic partner_page_load,
    input wire logic [15:0] partner_page,
    input wire logic [15:0] base_code_word,
    input wire logic further_page_request,
    input wire logic strap_loaded
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////
    // read answers and fixed fields
    chk_read_answer: assert property (reg_rd |=> reg_rvalid) else $error("no read answer");
    chk_rvalid_pulse: assert property (!reg_rd |=> !reg_rvalid)
        else $error("read answer without read");
    chk_fixed_zero: assert property (reg_rd && reg_addr == 5'h04 |=> !reg_rdata[14] && !reg_rdata[9])
        else $error("fixed zero bit set");
    chk_sel_read: assert property (reg_rd && reg_addr == 5'h04 |=> reg_rdata[4:0] == 5'h01)
        else $error("selector read wrong");
    chk_word_fixed: assert property (base_code_word[4:0] == 5'h01 && !base_code_word[14] && !base_code_word[9])
        else $error("code word fixed bits wrong");
    ////////////////////////////////////////////////////////////////
    // write, strap and partner paths
    chk_ctrl_write: assert property (reg_wr && reg_addr == 5'h04 ##1 !reg_wr |->
        ##1 (base_code_word & 16'h3c00) == ($past(reg_wdata, 2) & 16'h3c00)) else $error("control bits lost");
    chk_page_req: assert property (reg_wr && reg_addr == 5'h04 ##1 !reg_wr |->
        ##1 further_page_request == $past(reg_wdata[15], 2)) else $error("page request wrong");
    chk_strap_load: assert property ($rose(strap_loaded) |-> ##1 base_code_word[8:5] == speed_strap)
        else $error("strap default wrong");
    chk_partner_word: assert property (partner_page_load ##1 (reg_rd && reg_addr == 5'h05 && !partner_page_load)
        |=> reg_rdata == $past(partner_page, 2)) else $error("partner word wrong");
endmodule
bind ana_adv_regs ana_adv_monitor #(.ADDR_WIDTH(ADDR_WIDTH)) mon (.ref_clk, .rst, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata, .reg_rdata, .reg_rvalid, .speed_strap, .partner_page_load, .partner_page, .base_code_word,
    .further_page_request, .strap_loaded);

// ==== testbench/ana_link_partner.sv ====
`timescale 1ns/1ns
module ana_link_partner (
    input wire logic ref_clk,
    output logic partner_page_load,
    output logic [15:0] partner_page
);
    // idle: no page offered
    initial begin
        partner_page_load = 1'b0;
        partner_page = 16'h5a5a;
    end
    // one received base page as a single-cycle pulse, called at a falling edge
    task send(input logic [15:0] p);
        partner_page_load = 1'b1;
        partner_page = p;
        @(negedge ref_clk);
        partner_page_load = 1'b0;
        partner_page = ~p; // stale page must never be what gets stored
    endtask
endmodule

// ==== testbench/autoneg_advertise_regs_tb.sv ====
`timescale 1ns/1ns
module autoneg_advertise_regs_tb;
    import ana_adv_pkg::*;
    logic ref_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [4:0] reg_addr = 5'h00;
    ana_word_t reg_wdata = 16'h0000, reg_rdata, base_code_word, partner_page, d;
    ana_speed_t speed_strap = 4'hf;
    logic reg_rvalid, partner_page_load, further_page_request, strap_loaded;
    int num_errors = 0, total_checks = 0;
    ana_adv_regs dut (.ref_clk, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid,
        .speed_strap, .partner_page_load, .partner_page, .base_code_word, .further_page_request, .strap_loaded);
    ana_link_partner lp (.ref_clk, .partner_page_load, .partner_page);
    initial forever #5 ref_clk = ~ref_clk;
    ////////////////////////////////////////////////////////////////
    function ana_word_t adv_exp(input ana_word_t w);
        return (w & 16'hbde0) | 16'h0001; // writable bits kept, selector forced
    endfunction
    task check(input ana_word_t seen, input ana_word_t exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task test_done;
        $display("checks=%0d errors=%0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // reset with given straps, then wait for the straps to land
    task do_reset(input ana_speed_t s);
        speed_strap = s;
        rst = 1'b1;
        repeat (8) @(negedge ref_clk);
        rst = 1'b0;
        for (int i = 0; i < 20 && strap_loaded !== 1'b1; i++) @(negedge ref_clk);
        if (strap_loaded !== 1'b1) begin
            num_errors++;
            test_done();
        end
        repeat (2) @(negedge ref_clk);
    endtask
    task wr(input logic [4:0] a, input ana_word_t v);
        reg_addr = a;
        reg_wdata = v;
        reg_wr = 1'b1;
        @(negedge ref_clk);
        reg_wr = 1'b0;
        @(negedge ref_clk);
    endtask
    task rd(input logic [4:0] a, input ana_word_t exp);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge ref_clk);
        reg_rd = 1'b0;
        check({15'h0000, reg_rvalid}, 16'h0001);
        check(reg_rdata, exp);
        @(negedge ref_clk);
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'h564d));
        do_reset(4'hf);
        rd(5'h04, 16'h01e1);
        rd(5'h05, 16'h0000);
        $display("test reset done");
        for (int i = 0; i < 3; i++) begin
            d = 16'($urandom);
            do_reset(d[3:0]);
            rd(5'h04, {7'h00, d[3:0], 5'h01});
        end
        $display("test strap done");
        for (int i = 0; i < 12; i++) begin
            d = (i == 0) ? 16'hffff : (i == 1) ? 16'h0000 : 16'($urandom);
            wr(5'h04, d);
            rd(5'h04, adv_exp(d));
            check(base_code_word, adv_exp(d));
            check({15'h0000, further_page_request}, {15'h0000, d[15]});
        end
        $display("test write done");
        wr(5'h05, 16'hffff);
        rd(5'h05, 16'h0000);
        rd(5'h1f, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            d = 16'($urandom);
            lp.send(d);
            rd(5'h05, d);
        end
        $display("test partner done");
        test_done();
    end
endmodule
